/* File: src/tvr_map.vh */
// Constants for the trigger value recorder
// Summary of operation
// R1: On trigger, capture every selected magnitude into one recording entry.
// R2: Capture happens in the same cycle the trigger is seen.
// R3: Scaling select picks per-unit or primary values for all captures.
// R4: Settings enable storing overcurrent fault type, voltage fault type, or both.
// R5: Up to eight slots, each selecting one signal of the measurement set.
// R6: Each recording holds both fault types and the tripped stage identifier.
// R7: Twelve most recent recordings kept, each readable by index.
// R8: Any listed stage trip shows captured values and fault type on display.
// R9: Display view loads on trips only while the trigger-display enable is set.
// R10: Selected reset input clears the displayed fault values.
// R11: History is circular; a new recording overwrites the oldest when full.
`ifndef TVR_MAP_VH
`define TVR_MAP_VH
`define TVR_SLOTS 8
`define TVR_DEPTH 12
`define TVR_SEL_W 7
`define TVR_VAL_W 16
`define TVR_FT_W 4
`define TVR_STG_W 4
`define TVR_NSTG 7
`define TVR_IDX_W 4
`define TVR_SCALE_PU 1'b0
`define TVR_SCALE_PRI 1'b1
`endif

/* File: src/tvr_slot_mux.v */
// Per-slot selection of one measurement from the full measurement set
`timescale 1ns/100ps
module tvr_slot_mux
#(
  parameter SEL_W = 7,
  parameter VAL_W = 16,
  parameter NSIG = 128
)
(
  input wire [NSIG*VAL_W-1:0] sig_bus,
  input wire [SEL_W-1:0] sel,
  output wire [VAL_W-1:0] val
);
  // Index into the flat signal bus
  assign val = sig_bus[sel*VAL_W +: VAL_W]; // R5
endmodule

/* File: src/tvr_stage_enc.v */
// Priority encoder naming the tripped protection stage
`timescale 1ns/100ps
module tvr_stage_enc
#(
  parameter NSTG = 7,
  parameter STG_W = 4
)
(
  input wire [NSTG-1:0] trips,
  output reg [STG_W-1:0] stage_id,
  output reg any_trip
);
  integer i;
  // Lowest index wins; id is index plus one, zero means none
  always @*
  begin
    stage_id = {STG_W{1'b0}};
    any_trip = 1'b0;
    for (i = NSTG - 1; i >= 0; i = i - 1)
    begin
      if (trips[i])
      begin
        stage_id = i[STG_W-1:0] + 1'b1;
        any_trip = 1'b1;
      end
    end
  end
endmodule

/* File: src/tvr_top.v */
// Trigger value recorder: capture, history ring and fault display
`timescale 1ns/100ps
`include "tvr_map.vh"
module tvr_top
#(
  parameter SLOTS = `TVR_SLOTS,
  parameter DEPTH = `TVR_DEPTH,
  parameter SEL_W = `TVR_SEL_W,
  parameter VAL_W = `TVR_VAL_W,
  parameter FT_W = `TVR_FT_W,
  parameter STG_W = `TVR_STG_W,
  parameter NSTG = `TVR_NSTG,
  parameter IDX_W = `TVR_IDX_W
)
(
  input wire clk,
  input wire nrst,
  input wire trigger,
  input wire [NSTG-1:0] stage_trip,
  input wire [(1<<SEL_W)*VAL_W-1:0] meas_pu,
  input wire [(1<<SEL_W)*VAL_W-1:0] meas_pri,
  input wire [SLOTS*SEL_W-1:0] slot_sel,
  input wire [SLOTS-1:0] slot_en,
  input wire scale_sel,
  input wire oc_type_en,
  input wire volt_type_en,
  input wire [FT_W-1:0] oc_fault_type,
  input wire [FT_W-1:0] volt_fault_type,
  input wire fault_view_trigger_enable,
  input wire fault_clear,
  input wire [IDX_W-1:0] rd_idx,
  output reg [SLOTS*VAL_W-1:0] disp_vals_q,
  output reg [FT_W-1:0] disp_oc_type_q,
  output reg [FT_W-1:0] disp_volt_type_q,
  output reg [STG_W-1:0] disp_stage_q,
  output reg disp_valid_q,
  output reg [SLOTS*VAL_W-1:0] rd_vals_q,
  output reg [FT_W-1:0] rd_oc_type_q,
  output reg [FT_W-1:0] rd_volt_type_q,
  output reg [STG_W-1:0] rd_stage_q,
  output reg rd_valid_q,
  output reg [FT_W-1:0] rep_oc_type_q,
  output reg [FT_W-1:0] rep_volt_type_q,
  output reg [STG_W-1:0] rep_stage_q,
  output reg rep_strobe_q,
  output reg [IDX_W-1:0] rec_count_q
);

  localparam NSIG = 1 << SEL_W;
  localparam ENT_W = SLOTS*VAL_W + 2*FT_W + STG_W;
  // Entry field positions, values lowest
  localparam OC_LSB = SLOTS*VAL_W;
  localparam VOLT_LSB = OC_LSB + FT_W;
  localparam STG_LSB = VOLT_LSB + FT_W;

  // ****************************************
  // Operation overview
  // ****************************************
  // Capture path
  // Each slot picks one signal of the chosen scaling set.
  // Scaling choice is common to all slots of one capture.
  // Disabled slots carry zero, so unused fields are clean.
  // Fault type codes pass only when their enable is set.
  // Stage id is the lowest tripped stage plus one.
  // A stage id of zero means no stage was tripped.
  //
  // Trigger handling
  // Trigger is a level, sampled on every rising edge.
  // Every high cycle records one entry, back to back allowed.
  // Values are taken from the live inputs of that cycle.
  // No pipeline sits between trigger and sampling.
  // Upstream report strobes one cycle after each capture.
  // Report fields hold until the next capture.
  //
  // History ring
  // Twelve entries, each a plain bank of flip-flops.
  // Write pointer points at the slot for the next capture.
  // Pointer wraps after the last slot, over the oldest entry.
  // Record count climbs to the depth and then stays there.
  // Readout index zero is the newest recording.
  // Readout is registered, one cycle after the index.
  // Index at or beyond the count reads as not valid.
  // Index beyond the depth also reads as all zero.
  // A capture in the read cycle shows one cycle later.
  //
  // Fault display
  // Loads on any stage trip while the view is enabled.
  // Display capture does not wait for the trigger input.
  // With the view disabled, trips leave the display alone.
  // Clear input empties the display and drops its valid.
  // Trip with the view enabled wins over a clear in the same cycle.
  // Display fields hold until the next trip or clear.
  //
  // Limits
  // Inputs are taken as synchronous to the clock.
  // Measurement sets must be stable in the capture cycle.
  // Reset clears history, count, display and report.
  // No storage outside the ring, the write pointer and the output flops.
  // Trip levels held high reload the display each cycle while the view is enabled.

  // ****************************************
  // Live capture values
  // ****************************************
  wire [NSIG*VAL_W-1:0] meas_bus;
  wire [SLOTS*VAL_W-1:0] cap_vals;
  wire [STG_W-1:0] stage_id;
  wire any_trip;
  wire [FT_W-1:0] cap_oc;
  wire [FT_W-1:0] cap_volt;
  wire [ENT_W-1:0] cap_entry;

  // Scaling choice applies to every slot
  assign meas_bus = (scale_sel == `TVR_SCALE_PRI) ? meas_pri : meas_pu; // R3

  genvar g;
  generate
    for (g = 0; g < SLOTS; g = g + 1)
    begin : gen_slot
      wire [VAL_W-1:0] v;
      tvr_slot_mux #(.SEL_W(SEL_W), .VAL_W(VAL_W), .NSIG(NSIG)) u_mux
      (
        .sig_bus(meas_bus),
        .sel(slot_sel[g*SEL_W +: SEL_W]),
        .val(v)
      );
      // Disabled slots record zero
      assign cap_vals[g*VAL_W +: VAL_W] =
        slot_en[g] ? v : {VAL_W{1'b0}}; // R5
    end
  endgenerate

  tvr_stage_enc #(.NSTG(NSTG), .STG_W(STG_W)) u_enc
  (
    .trips(stage_trip),
    .stage_id(stage_id),
    .any_trip(any_trip)
  );

  // Fault types kept only when enabled
  assign cap_oc = oc_type_en ? oc_fault_type : {FT_W{1'b0}}; // R4
  assign cap_volt = volt_type_en ? volt_fault_type : {FT_W{1'b0}}; // R4
  assign cap_entry = {stage_id, cap_volt, cap_oc, cap_vals}; // R6

  // ****************************************
  // History ring
  // ****************************************
  wire [DEPTH*ENT_W-1:0] hist_flat;
  wire [DEPTH-1:0] ent_we;
  reg [IDX_W-1:0] wr_ptr_q;
  wire [IDX_W-1:0] wr_ptr_d;
  wire [IDX_W-1:0] last_idx;
  wire [IDX_W-1:0] depth_idx;
  wire count_full;
  wire [IDX_W-1:0] rec_count_d;
  wire [IDX_W-1:0] rd_slot;
  wire rd_in_range;
  wire [ENT_W-1:0] rd_entry;
  wire rd_valid_d;
  wire [SLOTS*VAL_W-1:0] rd_vals_w;
  wire [FT_W-1:0] rd_oc_w;
  wire [FT_W-1:0] rd_volt_w;
  wire [STG_W-1:0] rd_stage_w;

  // Depth and last slot at pointer width
  assign depth_idx = DEPTH[IDX_W-1:0];
  assign last_idx = depth_idx - 1'b1;

  // Wrap over the oldest entry
  assign wr_ptr_d = (wr_ptr_q == last_idx) ?
    {IDX_W{1'b0}} : wr_ptr_q + 1'b1; // R11

  // Count saturates once the ring is full
  assign count_full = (rec_count_q == depth_idx);
  assign rec_count_d = count_full ? rec_count_q :
    rec_count_q + 1'b1; // R7

  // One entry per step, written at the trigger cycle itself
  genvar e;
  generate
    for (e = 0; e < DEPTH; e = e + 1)
    begin : gen_ent
      reg [ENT_W-1:0] ent_q;
      // Entry hit by the write pointer
      assign ent_we[e] = trigger && (wr_ptr_q == e); // R1 R2
      // Entry flops, cleared by reset only
      always @(posedge clk or negedge nrst)
      begin
        if (!nrst)
          ent_q <= {ENT_W{1'b0}};
        else if (ent_we[e])
          ent_q <= cap_entry; // R7
      end
      assign hist_flat[e*ENT_W +: ENT_W] = ent_q;
    end
  endgenerate

  // Write pointer moves on every trigger, record count until it reaches the depth
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      wr_ptr_q <= {IDX_W{1'b0}};
      rec_count_q <= {IDX_W{1'b0}};
    end
    else if (trigger)
    begin
      wr_ptr_q <= wr_ptr_d; // R11
      rec_count_q <= rec_count_d; // R7
    end
  end

  // Index 0 is newest; map to ring slot
  assign rd_slot = (rd_idx < wr_ptr_q) ?
    wr_ptr_q - 1'b1 - rd_idx :
    wr_ptr_q + depth_idx - 1'b1 - rd_idx; // R7
  // Indexes past the ring depth read as zero
  assign rd_in_range = (rd_idx < depth_idx);
  assign rd_entry = rd_in_range ?
    hist_flat[rd_slot*ENT_W +: ENT_W] : {ENT_W{1'b0}};
  assign rd_valid_d = (rd_idx < rec_count_q); // R7

  // Split the selected entry into its fields
  assign rd_vals_w = rd_entry[OC_LSB-1:0];
  assign rd_oc_w = rd_entry[VOLT_LSB-1:OC_LSB];
  assign rd_volt_w = rd_entry[STG_LSB-1:VOLT_LSB];
  assign rd_stage_w = rd_entry[ENT_W-1:STG_LSB];

  // Registered history readout
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rd_vals_q <= {SLOTS*VAL_W{1'b0}};
      rd_oc_type_q <= {FT_W{1'b0}};
      rd_volt_type_q <= {FT_W{1'b0}};
      rd_stage_q <= {STG_W{1'b0}};
      rd_valid_q <= 1'b0;
    end
    else
    begin
      rd_vals_q <= rd_vals_w;
      rd_oc_type_q <= rd_oc_w;
      rd_volt_type_q <= rd_volt_w;
      rd_stage_q <= rd_stage_w;
      rd_valid_q <= rd_valid_d; // R7
    end
  end

  // ****************************************
  // Fault display and reporting
  // ****************************************
  wire disp_load;
  wire disp_clr;
  // Trip beats clear in the same cycle while the view is enabled
  assign disp_load = any_trip && fault_view_trigger_enable; // R8 R9
  assign disp_clr = fault_clear && !disp_load; // R10

  // Display loads on a stage trip while the view is enabled
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      disp_vals_q <= {SLOTS*VAL_W{1'b0}};
      disp_oc_type_q <= {FT_W{1'b0}};
      disp_volt_type_q <= {FT_W{1'b0}};
      disp_stage_q <= {STG_W{1'b0}};
      disp_valid_q <= 1'b0;
    end
    else if (disp_load) // R8 R9
    begin
      disp_vals_q <= cap_vals; // R8
      disp_oc_type_q <= cap_oc;
      disp_volt_type_q <= cap_volt;
      disp_stage_q <= stage_id;
      disp_valid_q <= 1'b1;
    end
    else if (disp_clr)
    begin
      disp_vals_q <= {SLOTS*VAL_W{1'b0}}; // R10
      disp_oc_type_q <= {FT_W{1'b0}};
      disp_volt_type_q <= {FT_W{1'b0}};
      disp_stage_q <= {STG_W{1'b0}};
      disp_valid_q <= 1'b0;
    end
  end

  // Upstream report of each recording
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rep_oc_type_q <= {FT_W{1'b0}};
      rep_volt_type_q <= {FT_W{1'b0}};
      rep_stage_q <= {STG_W{1'b0}};
      rep_strobe_q <= 1'b0;
    end
    else
    begin
      rep_strobe_q <= trigger;
      if (trigger)
      begin
        rep_oc_type_q <= cap_oc; // R6
        rep_volt_type_q <= cap_volt;
        rep_stage_q <= stage_id;
      end
    end
  end

endmodule

/* File: verif/tvr_checker.sv */
// Port assertions for the trigger value recorder
`timescale 1ns/100ps
module tvr_checker
#(
  parameter DEPTH = 12
)
(
  input wire clk,
  input wire nrst,
  input wire trigger,
  input wire [6:0] stage_trip,
  input wire oc_type_en,
  input wire volt_type_en,
  input wire [3:0] oc_fault_type,
  input wire [3:0] volt_fault_type,
  input wire fault_view_trigger_enable,
  input wire fault_clear,
  input wire [3:0] rd_idx,
  input wire [127:0] disp_vals_q,
  input wire [3:0] disp_stage_q,
  input wire disp_valid_q,
  input wire rd_valid_q,
  input wire [3:0] rep_oc_type_q,
  input wire [3:0] rep_volt_type_q,
  input wire rep_strobe_q,
  input wire [3:0] rec_count_q
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  // Enabled stage trip seen
  sequence s_trip_on;
    |stage_trip && fault_view_trigger_enable;
  endsequence
  a_cap_strobe: assert property (trigger |=> rep_strobe_q)
    else $error("no report after trigger");
  a_type_store: assert property (trigger |=>
    {rep_oc_type_q, rep_volt_type_q} ==
    {$past(oc_type_en) ? $past(oc_fault_type) : 4'h0,
    $past(volt_type_en) ? $past(volt_fault_type) : 4'h0})
    else $error("fault type report wrong");
  a_count_up: assert property (trigger && rec_count_q < DEPTH |=>
    rec_count_q == $past(rec_count_q) + 4'h1)
    else $error("count not advanced");
  a_count_cap: assert property (rec_count_q <= DEPTH)
    else $error("count above depth");
  a_rd_empty: assert property (!trigger && rd_idx >= rec_count_q
    |=> !rd_valid_q) else $error("empty slot read valid");
  a_disp_load: assert property (s_trip_on |=>
    disp_valid_q && disp_stage_q != 4'h0) else $error("trip not shown");
  a_view_off: assert property (!fault_view_trigger_enable &&
    !fault_clear |=> $stable(disp_vals_q) && $stable(disp_stage_q))
    else $error("display moved while off");
  a_clear_disp: assert property (fault_clear &&
    !(|stage_trip && fault_view_trigger_enable) |=>
    !disp_valid_q && disp_vals_q == 128'h0) else $error("not cleared");
endmodule
bind tvr_top tvr_checker #(.DEPTH(DEPTH)) u_chk (.*);

/* File: verif/tvr_meas_src.sv */
// Measurement source standing in for the calculation logic
`timescale 1ns/100ps
module tvr_meas_src
(
  input wire [15:0] base,
  output logic [2047:0] meas_pu,
  output logic [2047:0] meas_pri
);
  // Signal n reads base plus n, primary set offset by 16'h8000
  always_comb
    for (int n = 0; n < 128; n++)
    begin
      meas_pu[n*16+:16] = base + 16'(n);
      meas_pri[n*16+:16] = base + 16'(n) + 16'h8000;
    end
endmodule

/* File: verif/test_trigger_value_recorder.sv */
// Self-checking bench of the trigger value recorder
`timescale 1ns/100ps
module test_trigger_value_recorder;
  reg clk, nrst, trigger, scale_sel, oc_type_en, volt_type_en;
  reg fault_view_trigger_enable, fault_clear;
  reg [6:0] stage_trip;
  reg [55:0] slot_sel;
  reg [7:0] slot_en;
  reg [3:0] oc_fault_type, volt_fault_type, rd_idx;
  reg [15:0] base, r;
  wire [2047:0] meas_pu, meas_pri;
  wire [127:0] disp_vals_q, rd_vals_q;
  wire [3:0] disp_stage_q, disp_oc_type_q, disp_volt_type_q, rd_stage_q;
  wire [3:0] rd_oc_type_q, rd_volt_type_q, rec_count_q;
  wire [3:0] rep_oc_type_q, rep_volt_type_q, rep_stage_q;
  wire disp_valid_q, rd_valid_q, rep_strobe_q;
  logic [127:0] qv[$];
  logic [7:0] qt[$];
  logic [7:0] et;
  logic [3:0] qs[$];
  logic [3:0] es;
  integer fail_count, checked, i, k;
  tvr_top uut (.*);
  tvr_meas_src u_src (.base(base), .meas_pu(meas_pu), .meas_pri(meas_pri));
  // Random source
  function [15:0] nx(input [15:0] v);
    nx = {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  // Expected slot values from present settings
  function logic [127:0] cap();
    for (int s = 0; s < 8; s++)
      cap[s*16+:16] = slot_en[s] ? base + slot_sel[s*7+:7] +
        (scale_sel ? 16'h8000 : 16'h0) : 16'h0;
  endfunction
  // Expected stage: lowest set trip bit plus one
  function logic [3:0] stg(input logic [6:0] t);
    stg = 4'h0;
    for (int j = 6; j >= 0; j--)
      if (t[j])
        stg = 4'(j + 1);
  endfunction
  task chk(input logic [135:0] got, input logic [135:0] exp);
    checked++;
    if (got !== exp)
    begin
      fail_count++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task final_report;
    $display("mismatches %0d checks %0d", fail_count, checked);
    if (fail_count == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial
  begin
    clk = 0;
    forever #20 clk = ~clk;
  end
  // Hang guard
  initial
  begin
    #100000;
    fail_count++;
    final_report;
  end
  initial
  begin
    {nrst, trigger, stage_trip, scale_sel, oc_type_en, volt_type_en} = 0;
    {fault_view_trigger_enable, fault_clear, rd_idx, base} = 0;
    {slot_sel, slot_en, oc_fault_type, volt_fault_type} = 0;
    fail_count = 0;
    checked = 0;
    r = 16'h0021;
    repeat (10) @(posedge clk);
    #1 nrst = 1;
    // Back-to-back triggers, fourteen to wrap the history
    for (i = 0; i < 15; i++)
    begin
      @(posedge clk);
      #1;
      if (i > 0)
        chk({rep_strobe_q, rep_oc_type_q, rep_volt_type_q, rep_stage_q},
          {1'b1, et, es});
      r = nx(r);
      base = r;
      slot_sel = {r[7:0], r, nx(r), r};
      slot_en = r[15:8];
      scale_sel = r[0];
      oc_type_en = i[0];
      volt_type_en = i[1];
      oc_fault_type = r[4:1];
      volt_fault_type = r[8:5];
      stage_trip = r[11:5];
      trigger = i < 14;
      et = {oc_type_en ? oc_fault_type : 4'h0,
        volt_type_en ? volt_fault_type : 4'h0};
      es = stg(stage_trip);
      if (trigger)
      begin
        qv.push_front(cap());
        qt.push_front(et);
        qs.push_front(es);
      end
      if (qv.size() > 12)
      begin
        void'(qv.pop_back());
        void'(qt.pop_back());
        void'(qs.pop_back());
      end
    end
    @(posedge clk);
    #1 chk({rep_strobe_q, rec_count_q}, {1'b0, 4'hc});
    // History readout, newest first, one past the end
    for (k = 0; k < 13; k++)
    begin
      rd_idx = k[3:0];
      @(posedge clk);
      #1 chk(rd_valid_q, k < 12);
      if (k < 12)
      begin
        chk({rd_vals_q, rd_oc_type_q, rd_volt_type_q}, {qv[k], qt[k]});
        chk(rd_stage_q, qs[k]);
      end
    end
    // Every stage trip, then one with the view off
    for (k = 0; k < 8; k++)
    begin
      fault_view_trigger_enable = k < 7;
      stage_trip = 7'h01 << (k % 7);
      fault_clear = 0;
      @(posedge clk);
      #1 stage_trip = 0;
      fault_clear = 1;
      chk(disp_valid_q, k < 7);
      if (k < 7)
      begin
        chk({disp_stage_q, disp_vals_q}, {k[3:0] + 4'h1, cap()});
        chk({disp_oc_type_q, disp_volt_type_q}, et);
      end
      @(posedge clk);
      #1 chk({disp_valid_q, disp_vals_q}, 129'h0);
    end
    final_report;
  end
endmodule
